// file: ascl_strap_latch.v
// Strap capture at full reset and shared upper data pin multiplexer
`timescale 1ns/1ps
`default_nettype none
`include "ascl_map.vh"

module ascl_strap_latch #(
  parameter UPPER_W = `ASCL_UPPER_W,
  parameter OS_W = 3,
  parameter CNT_W = `ASCL_CNT_W,
  parameter [CNT_W-1:0] PARTIAL_CYC = `ASCL_PARTIAL_CYC,
  parameter [CNT_W-1:0] FULL_CYC = `ASCL_FULL_CYC
) (
  // Clock and reset
  input wire sys_clk,
  input wire sys_rst,
  // Host reset pin, active low
  input wire reset_pin_n,
  // Host strobes
  input wire cs_n,
  input wire rd_n,
  // Interface select, sampled at full reset release
  input wire serial_sel,
  // Dedicated strap inputs
  input wire single_output_strap,
  input wire range_mode_sel_hi,
  input wire range_mode_sel_lo,
  // Shared upper pins, data bit 9 at index 0
  input wire [UPPER_W-1:0] upper_pin_in,
  output reg [UPPER_W-1:0] upper_pin_out_q,
  output reg [UPPER_W-1:0] upper_pin_oe_q,
  // Result data from the conversion core
  input wire [UPPER_W-1:0] par_data_hi,
  input wire serial_out_first,
  input wire serial_out_second,
  // Captured configuration
  output reg byte_mode_q,
  output reg serial_mode_q,
  output reg second_out_en_q,
  output reg [OS_W-1:0] oversample_ratio_q,
  output reg sw_mode_q,
  output reg [1:0] range_code_q,
  // Serial configuration input as seen by the register logic
  output reg serial_config_in_q,
  // Reset status
  output reg in_reset_q,
  output reg full_reset_pulse_q,
  output reg partial_reset_pulse_q
);

  // ----------------------------------------------------------------
  // Reset pulse qualifier
  // ----------------------------------------------------------------
  wire hold_w;
  wire partial_rel_w;
  wire full_rel_w;

  ascl_reset_qual #(
    .CNT_W(CNT_W),
    .PARTIAL_CYC(PARTIAL_CYC),
    .FULL_CYC(FULL_CYC)
  ) u_qual (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .reset_pin_n(reset_pin_n),
    .hold_q(hold_w),
    .partial_rel_q(partial_rel_w),
    .full_rel_q(full_rel_w)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function is_sw_code;
    input [1:0] code;
    begin
      is_sw_code = (code == `ASCL_RNG_SW);
    end
  endfunction

  wire [1:0] range_pins_w;
  wire [OS_W-1:0] os_pins_w;
  wire read_strobe_w;
  wire quiet_w;

  assign range_pins_w = {range_mode_sel_hi, range_mode_sel_lo};
  assign os_pins_w = upper_pin_in[`ASCL_PIN_OS_HI:`ASCL_PIN_OS_LO];
  assign read_strobe_w = ~cs_n & ~rd_n;
  // The full release cycle is kept quiet too: straps are sampled then
  assign quiet_w = hold_w | full_rel_w;

  // ----------------------------------------------------------------
  // Interface mode decode
  // ----------------------------------------------------------------
  // Serial wins when both straps are high, so the serial outputs keep
  // working however the byte strap was left; the byte port then stays off.
  localparam [1:0] IFM_WORD = 2'h0;
  localparam [1:0] IFM_BYTE = 2'h1;
  localparam [1:0] IFM_SERIAL = 2'h2;

  function [1:0] if_mode;
    input serial;
    input byte_port;
    begin
      if (serial) begin
        if_mode = IFM_SERIAL;
      end else if (byte_port) begin
        if_mode = IFM_BYTE;
      end else begin
        if_mode = IFM_WORD;
      end
    end
  endfunction

  wire [1:0] if_mode_w;
  assign if_mode_w = if_mode(serial_mode_q, byte_mode_q);

  // ----------------------------------------------------------------
  // Strap capture
  // ----------------------------------------------------------------
  // Straps reconfigure only on a full reset; a partial reset leaves
  // the interface choice alone so an in-flight host keeps working.
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      byte_mode_q <= `ASCL_RST_BYTE;
      serial_mode_q <= `ASCL_RST_SERIAL;
      second_out_en_q <= `ASCL_RST_SO2_EN;
      oversample_ratio_q <= `ASCL_RST_OSR;
      sw_mode_q <= `ASCL_RST_SW_MODE;
    end else if (full_rel_w) begin
      byte_mode_q <= upper_pin_in[`ASCL_PIN_BYTE];
      serial_mode_q <= serial_sel;
      second_out_en_q <= single_output_strap;
      oversample_ratio_q <= os_pins_w;
      sw_mode_q <= is_sw_code(range_pins_w);
    end
  end

  // ----------------------------------------------------------------
  // Range select
  // ----------------------------------------------------------------
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      range_code_q <= `ASCL_RST_RANGE;
    end else if (full_rel_w) begin
      range_code_q <= range_pins_w;
    end else if (~sw_mode_q) begin
      range_code_q <= range_pins_w;
    end else begin
      // Software mode: pins held off until the next full reset
      range_code_q <= `ASCL_RNG_SW;
    end
  end

  // ----------------------------------------------------------------
  // Serial configuration input
  // ----------------------------------------------------------------
  // Only meaningful in software serial mode; elsewhere forced low so
  // stray levels on the shared pin cannot reach the register logic.
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      serial_config_in_q <= 1'b0;
    end else if (hold_w | partial_rel_w) begin
      serial_config_in_q <= 1'b0;
    end else if ((if_mode_w == IFM_SERIAL) & sw_mode_q) begin
      serial_config_in_q <= upper_pin_in[`ASCL_PIN_CFG_IN];
    end else begin
      serial_config_in_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  reg [UPPER_W-1:0] out_d;
  reg [UPPER_W-1:0] oe_d;

  always @* begin
    out_d = {UPPER_W{1'b0}};
    oe_d = {UPPER_W{1'b0}};
    if (quiet_w) begin
      out_d = {UPPER_W{1'b0}};
      oe_d = {UPPER_W{1'b0}};
    end else if (if_mode_w == IFM_SERIAL) begin
      out_d[`ASCL_PIN_SO_1ST] = serial_out_first;
      oe_d[`ASCL_PIN_SO_1ST] = 1'b1;
      out_d[`ASCL_PIN_SO_2ND] = serial_out_second & second_out_en_q;
      oe_d[`ASCL_PIN_SO_2ND] = second_out_en_q;
    end else if (if_mode_w == IFM_BYTE) begin
      // Byte port uses the low pins only; upper pins are tied externally
      out_d = {UPPER_W{1'b0}};
      oe_d = {UPPER_W{1'b0}};
    end else if (read_strobe_w) begin
      out_d = par_data_hi;
      oe_d = {UPPER_W{1'b1}};
    end
  end

  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      upper_pin_out_q <= {UPPER_W{1'b0}};
      upper_pin_oe_q <= {UPPER_W{1'b0}};
    end else begin
      upper_pin_out_q <= out_d;
      upper_pin_oe_q <= oe_d;
    end
  end

  // ----------------------------------------------------------------
  // Reset status
  // ----------------------------------------------------------------
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      in_reset_q <= 1'b0;
      full_reset_pulse_q <= 1'b0;
      partial_reset_pulse_q <= 1'b0;
    end else begin
      in_reset_q <= hold_w;
      full_reset_pulse_q <= full_rel_w;
      partial_reset_pulse_q <= partial_rel_w;
    end
  end

endmodule
`default_nettype wire

// file: ascl_map.vh
// Constants for the strap capture and shared-pin multiplexer
//
// Function
// - Word-wide parallel mode: upper pins are bidirectional data bits 9 to 15.
// - Byte-port strap sampled at full reset release; high selects byte interface.
// - Software serial mode takes config bits on serial input; byte mode host holds low.
// - Second serial output driven in serial mode only if strap enabled it.
// - Serial mode always drives results on first serial output pin.
// - Three oversampling selects captured at full reset release, later changes ignored.
// - Range/mode selects latched at full reset; code 00 means software mode.
// - Hardware mode follows range selects continuously: 01, 10, 11 pick ranges.
// - Software mode ignores range select changes until next full reset.
// - Reset pulse length decides partial or full reset.
// - Parallel modes drive bus only while chip select and read both low.
`ifndef ASCL_MAP_VH
`define ASCL_MAP_VH

// ----------------------------------------------------------------
// Shared pin positions within the upper pin group (data bit 9 = 0)
// ----------------------------------------------------------------
`define ASCL_PIN_BYTE 0
`define ASCL_PIN_CFG_IN 1
`define ASCL_PIN_SO_2ND 2
`define ASCL_PIN_SO_1ST 3
`define ASCL_PIN_OS_LO 4
`define ASCL_PIN_OS_HI 6
`define ASCL_UPPER_W 7

// ----------------------------------------------------------------
// Range/mode select codes
// ----------------------------------------------------------------
`define ASCL_RNG_SW 2'h0
`define ASCL_RNG_2V5 2'h1
`define ASCL_RNG_5V 2'h2
`define ASCL_RNG_10V 2'h3

// ----------------------------------------------------------------
// Reset values of captured straps
// ----------------------------------------------------------------
`define ASCL_RST_BYTE 1'b0
`define ASCL_RST_SERIAL 1'b0
`define ASCL_RST_SO2_EN 1'b0
`define ASCL_RST_OSR 3'h0
`define ASCL_RST_SW_MODE 1'b1
`define ASCL_RST_RANGE 2'h0

// ----------------------------------------------------------------
// Reset pulse timing
// ----------------------------------------------------------------
`define ASCL_CLK_MHZ 100
`define ASCL_T_PARTIAL_NS 50
`define ASCL_T_FULL_NS 1200
`define ASCL_PARTIAL_CYC ((`ASCL_T_PARTIAL_NS * `ASCL_CLK_MHZ + 999) / 1000)
`define ASCL_FULL_CYC ((`ASCL_T_FULL_NS * `ASCL_CLK_MHZ + 999) / 1000)
`define ASCL_CNT_W 12

`endif

// file: ascl_reset_qual.v
// Reset pulse length qualifier: tells partial from full reset
`timescale 1ns/1ps
`default_nettype none
`include "ascl_map.vh"

module ascl_reset_qual #(
  parameter CNT_W = `ASCL_CNT_W,
  parameter [CNT_W-1:0] PARTIAL_CYC = `ASCL_PARTIAL_CYC,
  parameter [CNT_W-1:0] FULL_CYC = `ASCL_FULL_CYC
) (
  // Clock and reset
  input wire sys_clk,
  input wire sys_rst,
  // Host reset pin
  input wire reset_pin_n,
  // Classification
  output reg hold_q,
  output reg partial_rel_q,
  output reg full_rel_q
);

  reg [CNT_W-1:0] low_cnt_q;
  reg prev_n_q;
  wire release_w;

  assign release_w = reset_pin_n & ~prev_n_q;

  // ----------------------------------------------------------------
  // Low-time counter
  // ----------------------------------------------------------------
  // Saturates at the full threshold so a very long hold cannot wrap
  // and be mistaken for a short one.
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      low_cnt_q <= {CNT_W{1'b0}};
      prev_n_q <= 1'b1;
      hold_q <= 1'b0;
      partial_rel_q <= 1'b0;
      full_rel_q <= 1'b0;
    end else begin
      prev_n_q <= reset_pin_n;
      hold_q <= ~reset_pin_n;
      if (~reset_pin_n) begin
        if (low_cnt_q < FULL_CYC) begin
          low_cnt_q <= low_cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
        end
      end else begin
        low_cnt_q <= {CNT_W{1'b0}};
      end
      // Pulses shorter than the partial threshold are treated as glitches
      full_rel_q <= release_w & (low_cnt_q >= FULL_CYC);
      partial_rel_q <= release_w & (low_cnt_q >= PARTIAL_CYC) & (low_cnt_q < FULL_CYC);
    end
  end

endmodule
`default_nettype wire

// file: ascl_properties.sv
// Checker for strap capture, reset kind and shared pin drive
`timescale 1ns/1ps
`default_nettype none
module ascl_props #(
  parameter int UPPER_W = 7,
  parameter int PARTIAL_CYC = 5,
  parameter int FULL_CYC = 120
) (
  // Clock, resets and host strobes
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic reset_pin_n,
  input wire logic cs_n,
  input wire logic rd_n,
  // Strap and data inputs
  input wire logic serial_sel,
  input wire logic single_output_strap,
  input wire logic range_mode_sel_hi,
  input wire logic range_mode_sel_lo,
  input wire logic [UPPER_W-1:0] upper_pin_in,
  input wire logic [UPPER_W-1:0] par_data_hi,
  input wire logic serial_out_first,
  input wire logic serial_out_second,
  // Design outputs
  input wire logic [UPPER_W-1:0] upper_pin_out_q,
  input wire logic [UPPER_W-1:0] upper_pin_oe_q,
  input wire logic byte_mode_q,
  input wire logic serial_mode_q,
  input wire logic second_out_en_q,
  input wire logic [2:0] oversample_ratio_q,
  input wire logic sw_mode_q,
  input wire logic [1:0] range_code_q,
  input wire logic serial_config_in_q,
  input wire logic in_reset_q,
  input wire logic full_reset_pulse_q,
  input wire logic partial_reset_pulse_q
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // Length of the last low pulse on the host reset pin
  logic [11:0] low_q;
  logic [11:0] run_q;
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      low_q <= 12'h000;
      run_q <= 12'h000;
    end else begin
      low_q <= reset_pin_n ? 12'h000 : low_q + 12'h001;
      if (reset_pin_n && low_q != 12'h000) run_q <= low_q;
    end
  end
  // Pin high for three samples: outside reset and its release cycle
  sequence s_up;
    reset_pin_n && $past(reset_pin_n) && $past(reset_pin_n, 2);
  endsequence
  // The pin is sampled, then registered drive follows one edge later
  property p_no_drive; !reset_pin_n |=> ##1 upper_pin_oe_q == '0; endproperty
  a_no_drive: assert property (p_no_drive) else $error("pins driven in reset");
  property p_rel_quiet; full_reset_pulse_q |-> upper_pin_oe_q == '0; endproperty
  a_rel_quiet: assert property (p_rel_quiet) else $error("pins driven at capture");
  property p_in_reset;
    !$past(sys_rst) && !$past(sys_rst, 2) |-> in_reset_q == !$past(reset_pin_n, 2);
  endproperty
  a_in_reset: assert property (p_in_reset) else $error("reset status wrong");
  property p_word;
    s_up ##0 (!serial_mode_q && !byte_mode_q && !cs_n && !rd_n)
      |=> upper_pin_oe_q == '1 && upper_pin_out_q == $past(par_data_hi);
  endproperty
  a_word: assert property (p_word) else $error("word read drive wrong");
  property p_strobe; !serial_mode_q && (cs_n || rd_n) |=> upper_pin_oe_q == '0; endproperty
  a_strobe: assert property (p_strobe) else $error("bus driven without strobes");
  property p_byte; byte_mode_q |=> upper_pin_oe_q == '0; endproperty
  a_byte: assert property (p_byte) else $error("upper pins driven in byte mode");
  property p_capture;
    full_reset_pulse_q |-> byte_mode_q == $past(upper_pin_in[0])
      && serial_mode_q == $past(serial_sel) && second_out_en_q == $past(single_output_strap)
      && oversample_ratio_q == $past(upper_pin_in[6:4])
      && sw_mode_q == ($past({range_mode_sel_hi, range_mode_sel_lo}) == 2'h0);
  endproperty
  a_capture: assert property (p_capture) else $error("strap capture wrong");
  property p_hw_range;
    !sw_mode_q && $past(!sw_mode_q)
      |-> range_code_q == $past({range_mode_sel_hi, range_mode_sel_lo});
  endproperty
  a_hw_range: assert property (p_hw_range) else $error("range not followed");
  property p_sw_range; sw_mode_q |-> range_code_q == 2'h0; endproperty
  a_sw_range: assert property (p_sw_range) else $error("range used in sw mode");
  property p_first;
    s_up ##0 serial_mode_q
      |=> upper_pin_oe_q[3] && upper_pin_out_q[3] == $past(serial_out_first);
  endproperty
  a_first: assert property (p_first) else $error("first serial out wrong");
  property p_second;
    s_up ##0 serial_mode_q |=> upper_pin_oe_q[2] == $past(second_out_en_q);
  endproperty
  a_second: assert property (p_second) else $error("second serial out wrong");
  property p_cfg_in;
    s_up ##0 (serial_mode_q && sw_mode_q) |=> serial_config_in_q == $past(upper_pin_in[1]);
  endproperty
  a_cfg_in: assert property (p_cfg_in) else $error("serial config input lost");
  property p_kind;
    $rose(reset_pin_n) |-> ##2 (full_reset_pulse_q == (run_q >= FULL_CYC)
      && partial_reset_pulse_q == (run_q >= PARTIAL_CYC && run_q < FULL_CYC));
  endproperty
  a_kind: assert property (p_kind) else $error("reset kind wrong");
endmodule
bind ascl_strap_latch ascl_props #(
  .UPPER_W(UPPER_W),
  .PARTIAL_CYC(PARTIAL_CYC),
  .FULL_CYC(FULL_CYC)
) u_props (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .reset_pin_n(reset_pin_n), .cs_n(cs_n), .rd_n(rd_n),
  .serial_sel(serial_sel), .single_output_strap(single_output_strap),
  .range_mode_sel_hi(range_mode_sel_hi), .range_mode_sel_lo(range_mode_sel_lo),
  .upper_pin_in(upper_pin_in), .par_data_hi(par_data_hi),
  .serial_out_first(serial_out_first), .serial_out_second(serial_out_second),
  .upper_pin_out_q(upper_pin_out_q), .upper_pin_oe_q(upper_pin_oe_q),
  .byte_mode_q(byte_mode_q), .serial_mode_q(serial_mode_q),
  .second_out_en_q(second_out_en_q), .oversample_ratio_q(oversample_ratio_q),
  .sw_mode_q(sw_mode_q), .range_code_q(range_code_q),
  .serial_config_in_q(serial_config_in_q), .in_reset_q(in_reset_q),
  .full_reset_pulse_q(full_reset_pulse_q), .partial_reset_pulse_q(partial_reset_pulse_q)
);
`default_nettype wire

// file: ascl_host_model.sv
// Host side of the shared pins: strap levels and wire resolution
`timescale 1ns/1ps
`default_nettype none
module ascl_host_model (
  // Device drive
  input wire logic [6:0] oe,
  input wire logic [6:0] drv,
  // Host straps and mode
  input wire logic [6:0] strap,
  input wire logic byte_mode,
  // Resolved levels
  output logic [6:0] pin
);
  always_comb begin
    pin = (oe & drv) | (~oe & strap);
    // Serial pins tied low by the host in byte mode
    if (byte_mode) pin[3:1] = pin[3:1] & oe[3:1];
  end
endmodule
`default_nettype wire

// file: tb.sv
// Testbench for strap capture and shared pin multiplexer
`timescale 1ns/1ps
`default_nettype none
module tb;
  typedef struct packed {
    logic [3:0] n;
    logic ser;
    logic so2;
    logic [1:0] rng;
    logic [6:0] pins;
    logic [15:0] exp;
  } ascl_row_t;
  // Expect {full, partial, byte, serial, second, sw, osr, range}
  ascl_row_t rows [7] = '{'{4'h8, 1'b0, 1'b0, 2'h0, 7'h51, 16'h0534},
    '{4'h6, 1'b1, 1'b1, 2'h1, 7'h20, 16'h04C9}, '{4'h5, 1'b0, 1'b0, 2'h0, 7'h71, 16'h02C8},
    '{4'h2, 1'b0, 1'b0, 2'h0, 7'h71, 16'h02C8}, '{4'h1, 1'b0, 1'b0, 2'h0, 7'h71, 16'h00C8},
    '{4'h6, 1'b0, 1'b0, 2'h2, 7'h70, 16'h041E}, '{4'h6, 1'b0, 1'b0, 2'h3, 7'h30, 16'h040F}};
  logic sys_clk = 1'b0, sys_rst = 1'b1, rst_pin_n = 1'b1, cs_n = 1'b1, rd_n = 1'b1;
  logic ser = 1'b0, so2 = 1'b0, so_a = 1'b0, so_b = 1'b0, byte_q, ser_q, so2_q, sw_q, cfg_q;
  logic full_p, part_p, ir;
  logic [1:0] rng = 2'h0, rng_q;
  logic [2:0] os_q;
  logic [6:0] strap = 7'h00, par = 7'h00, pin, oe, drv;
  int bad_count = 0, n_compared = 0;
  always #5 sys_clk = ~sys_clk;
  ascl_strap_latch #(.PARTIAL_CYC(12'h002), .FULL_CYC(12'h006)) u_dut (.sys_clk(sys_clk),
    .sys_rst(sys_rst), .reset_pin_n(rst_pin_n), .cs_n(cs_n), .rd_n(rd_n), .serial_sel(ser),
    .single_output_strap(so2), .range_mode_sel_hi(rng[1]), .range_mode_sel_lo(rng[0]),
    .upper_pin_in(pin), .upper_pin_out_q(drv), .upper_pin_oe_q(oe), .par_data_hi(par),
    .serial_out_first(so_a), .serial_out_second(so_b), .byte_mode_q(byte_q),
    .serial_mode_q(ser_q), .second_out_en_q(so2_q), .oversample_ratio_q(os_q),
    .sw_mode_q(sw_q), .range_code_q(rng_q), .serial_config_in_q(cfg_q), .in_reset_q(ir),
    .full_reset_pulse_q(full_p), .partial_reset_pulse_q(part_p));
  ascl_host_model u_host (.oe(oe), .drv(drv), .strap(strap), .byte_mode(byte_q), .pin(pin));
  task chk(input logic [15:0] s, input logic [15:0] e);
    n_compared++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] %0t seen %h exp %h", $time, s, e);
    end
  endtask
  task settle;
    @(posedge sys_clk);
    #1;
  endtask
  // Host reset pin low for n samples, returns just after the capture edge
  task pulse(input int n);
    @(posedge sys_clk);
    rst_pin_n <= 1'b0;
    repeat (n) @(posedge sys_clk);
    rst_pin_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
  endtask
  task test_done;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #200000;
    bad_count++;
    test_done;
  end
  initial begin
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 7; i++) begin
      @(posedge sys_clk);
      ser <= rows[i].ser;
      so2 <= rows[i].so2;
      rng <= rows[i].rng;
      strap <= rows[i].pins;
      pulse(rows[i].n);
      chk({5'h00, full_p, part_p, byte_q, ser_q, so2_q, sw_q, os_q, rng_q}, rows[i].exp);
      $display("row %0d done", i);
    end
    @(posedge sys_clk);
    rng <= 2'h1;
    settle;
    chk({14'h0000, rng_q}, 16'h0001);
    @(posedge sys_clk);
    cs_n <= 1'b0;
    rd_n <= 1'b0;
    par <= 7'h5A;
    settle;
    chk({2'h0, oe, drv}, 16'h3FDA);
    @(posedge sys_clk);
    rd_n <= 1'b1;
    settle;
    chk({9'h000, oe}, 16'h0000);
    $display("word test done");
    @(posedge sys_clk);
    ser <= 1'b1;
    so2 <= 1'b0;
    rng <= 2'h0;
    strap <= 7'h02;
    so_a <= 1'b1;
    so_b <= 1'b1;
    pulse(6);
    settle;
    chk({7'h00, oe, drv[3], cfg_q}, 16'h0023);
    @(posedge sys_clk);
    rng <= 2'h3;
    strap <= 7'h72;
    repeat (2) settle;
    chk({11'h000, rng_q, os_q}, 16'h0000);
    @(posedge sys_clk);
    so2 <= 1'b1;
    strap <= 7'h00;
    pulse(6);
    settle;
    chk({8'h00, oe, drv[2]}, 16'h0019);
    $display("serial test done");
    // Host reset held low: status flag up and pins released two edges on
    @(posedge sys_clk);
    rst_pin_n <= 1'b0;
    repeat (2) settle;
    chk({7'h00, oe, ir}, 16'h0001);
    // Mid-run system reset, then its release
    @(posedge sys_clk);
    rst_pin_n <= 1'b1;
    sys_rst <= 1'b1;
    settle;
    chk({5'h00, full_p, part_p, byte_q, ser_q, so2_q, sw_q, os_q, rng_q}, 16'h0020);
    chk({6'h00, oe, cfg_q, ir, drv[3]}, 16'h0000);
    @(posedge sys_clk);
    sys_rst <= 1'b0;
    repeat (2) settle;
    chk({5'h00, full_p, part_p, byte_q, ser_q, so2_q, sw_q, os_q, rng_q}, 16'h0020);
    chk({6'h00, oe, cfg_q, ir, drv[3]}, 16'h0000);
    $display("reset test done");
    test_done;
  end
endmodule
`default_nettype wire
